/* File: inc/lpm_pkg.sv */
// Package for the low-power mode sequencer: offsets, layouts, reset values, timing
package lpm_pkg;
  localparam logic [11:0] OFF_STANDBY_CTRL = 12'h000;
  localparam logic [11:0] OFF_DEEP_CTRL = 12'h004;
  localparam logic [11:0] OFF_MSTOP_A = 12'h008;
  localparam logic [11:0] OFF_MSTOP_B = 12'h00C;
  localparam logic [11:0] OFF_MSTOP_C = 12'h010;
  localparam logic [11:0] OFF_STATUS = 12'h014;
  localparam logic [11:0] OFF_WAKE_ENABLE = 12'h018;

  // Bit positions
  localparam int BIT_STANDBY_SELECT = 15;
  localparam int BIT_DEEP_STANDBY_SELECT = 7;
  localparam int BIT_RAM0_RETAIN = 0;
  localparam int BIT_ALL_CLOCK_STOP_ENABLE = 31;
  localparam int BIT_TIMER_KEEP_RUNNING = 5;

  // Reset values
  localparam logic [31:0] RST_STANDBY_CTRL = 32'h0000_0000;
  localparam logic [31:0] RST_DEEP_CTRL = 32'h0000_0000;
  localparam logic [31:0] RST_MSTOP_A = 32'h4FFF_FFCF;
  localparam logic [31:0] RST_MSTOP_B = 32'hFFFF_FFFF;
  localparam logic [31:0] RST_MSTOP_C = 32'hFFFF_0000;
  localparam logic [31:0] RST_WAKE_ENABLE = 32'hFFFF_FFFF;

  // All-clock-stop qualification patterns on module stop A and C
  localparam logic [31:0] MSTOP_A_MASK = 32'hFFFF_FFCF;
  localparam logic [31:0] MSTOP_A_MATCH = 32'hFFFF_FFCF;
  localparam logic [15:0] MSTOP_C_HIGH_ONES = 16'hFFFF;

  // Internal reset hold after deep wake
  localparam int DEEP_RESET_HOLD_NS = 1000;
  localparam int CLK_PERIOD_NS = 8;
  localparam int DEEP_RESET_CYCLES = (DEEP_RESET_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    LPM_NORMAL,
    LPM_SLEEP,
    LPM_ALL_CLOCK_STOP,
    LPM_SW_STANDBY,
    LPM_DEEP_STANDBY,
    LPM_DEEP_RESET
  } lpm_mode_e;

  // Peripheral wake sources
  typedef struct packed {
    logic timer8;
    logic rtc_alarm;
    logic rtc_period;
    logic watchdog;
    logic usb_suspend_resume;
    logic volt_mon1;
    logic volt_mon2;
    logic osc_stop;
  } lpm_periph_wake_s;

  // Deep standby pin wake sources
  typedef struct packed {
    logic [15:0] deep_wake_ext_line;
    logic deep_wake_serial_clock;
    logic deep_wake_serial_data;
    logic deep_wake_can_receive;
  } lpm_deep_pins_s;

  typedef struct packed {
    logic cpu_clk_en;
    logic module_clk_en;
    logic timer_clk_en;
    logic module_retain;
    logic module_power_off;
    logic ram0_power_off;
    logic internal_reset;
    logic clk_from_low_speed_onchip_osc;
  } lpm_ctrl_s;
endpackage

/* File: rtl/lpm_sequencer.sv */
// Low-power mode sequencer with APB register access
`timescale 1ns/1ps
// How it works
// - Wait picks clock stop if fully qualified, else sleep
// - NMI and ext lines wake clock stop, standby
// - Clock stop also woken by listed peripherals
// - Wait with standby, no deep: software standby
// - Standby woken by peripherals except timer, osc-stop
// - Wait with standby and deep: deep standby
// - Deep standby woken only by listed sources
// - Deep wake holds internal reset, releases together
// - After deep recovery run normal on low-speed oscillator
// - Timer pair may keep running in clock stop
// - Retained modules keep registers, resume later
// - Undetermined modules powered off, contents undefined
// - RAM0 retention in deep standby is selectable
module lpm_sequencer #(
  parameter int DEEP_HOLD = lpm_pkg::DEEP_RESET_CYCLES
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic wait_exec,
  input wire logic [15:0] irq_pending,
  input wire logic nmi,
  input wire logic [15:0] ext_irq,
  input wire lpm_pkg::lpm_periph_wake_s periph_wake,
  input wire lpm_pkg::lpm_deep_pins_s deep_pins,
  output lpm_pkg::lpm_ctrl_s ctrl,
  output lpm_pkg::lpm_mode_e mode
);
  lpm_pkg::lpm_mode_e next_mode;
  logic [31:0] standby_control_reg, next_standby_control_reg;
  logic [31:0] deep_standby_control_reg, next_deep_standby_control_reg;
  logic [31:0] module_stop_ctrl_a, next_module_stop_ctrl_a;
  logic [31:0] module_stop_ctrl_b, next_module_stop_ctrl_b;
  logic [31:0] module_stop_ctrl_c, next_module_stop_ctrl_c;
  logic [31:0] wake_enable, next_wake_enable;
  logic [31:0] next_prdata;
  logic next_pready, next_pslverr;
  logic [15:0] hold_cnt, next_hold_cnt;
  lpm_pkg::lpm_ctrl_s next_ctrl;
  logic deep_recovered, next_deep_recovered;
  logic wr_ok, rd_ok;
  logic ext_wake, clock_stop_ok, wake_sleep, wake_acs, wake_ssb, wake_deep;

  function automatic logic addr_mapped(input logic [11:0] a);
    addr_mapped = (a == lpm_pkg::OFF_STANDBY_CTRL) || (a == lpm_pkg::OFF_DEEP_CTRL) ||
                  (a == lpm_pkg::OFF_MSTOP_A) || (a == lpm_pkg::OFF_MSTOP_B) ||
                  (a == lpm_pkg::OFF_MSTOP_C) || (a == lpm_pkg::OFF_STATUS) ||
                  (a == lpm_pkg::OFF_WAKE_ENABLE);
  endfunction

  // APB: one wait state; a write lands only at the edge where the master sees pready high
  assign wr_ok = psel && penable && pready && pwrite;
  assign rd_ok = psel && penable && !pready && !pwrite;

  // Wake conditions
  assign ext_wake = nmi || (|(ext_irq & wake_enable[15:0]));
  assign clock_stop_ok = module_stop_ctrl_a[lpm_pkg::BIT_ALL_CLOCK_STOP_ENABLE] &&
                         ((module_stop_ctrl_a & lpm_pkg::MSTOP_A_MASK) == lpm_pkg::MSTOP_A_MATCH) &&
                         (module_stop_ctrl_b == 32'hFFFF_FFFF) &&
                         (module_stop_ctrl_c[31:16] == lpm_pkg::MSTOP_C_HIGH_ONES);
  assign wake_sleep = nmi || (|irq_pending) || ext_wake;
  assign wake_acs = ext_wake || periph_wake.timer8 || periph_wake.rtc_alarm || periph_wake.rtc_period ||
                    periph_wake.watchdog || periph_wake.usb_suspend_resume || periph_wake.volt_mon1 ||
                    periph_wake.volt_mon2 || periph_wake.osc_stop;
  assign wake_ssb = ext_wake || periph_wake.rtc_alarm || periph_wake.rtc_period || periph_wake.watchdog ||
                    periph_wake.usb_suspend_resume || periph_wake.volt_mon1 || periph_wake.volt_mon2;
  assign wake_deep = nmi || (|deep_pins.deep_wake_ext_line) || deep_pins.deep_wake_serial_clock ||
                     deep_pins.deep_wake_serial_data || deep_pins.deep_wake_can_receive ||
                     periph_wake.rtc_alarm || periph_wake.rtc_period || periph_wake.usb_suspend_resume ||
                     periph_wake.volt_mon1 || periph_wake.volt_mon2;

  always_comb begin
    next_mode = mode;
    next_hold_cnt = hold_cnt;
    next_deep_recovered = deep_recovered;
    case (mode)
      lpm_pkg::LPM_NORMAL: begin
        if (wait_exec) begin
          if (!standby_control_reg[lpm_pkg::BIT_STANDBY_SELECT]) begin
            next_mode = clock_stop_ok ? lpm_pkg::LPM_ALL_CLOCK_STOP : lpm_pkg::LPM_SLEEP;
          end else if (deep_standby_control_reg[lpm_pkg::BIT_DEEP_STANDBY_SELECT]) begin
            next_mode = lpm_pkg::LPM_DEEP_STANDBY;
          end else begin
            next_mode = lpm_pkg::LPM_SW_STANDBY;
          end
        end
      end
      lpm_pkg::LPM_SLEEP: if (wake_sleep) next_mode = lpm_pkg::LPM_NORMAL;
      lpm_pkg::LPM_ALL_CLOCK_STOP: if (wake_acs) next_mode = lpm_pkg::LPM_NORMAL;
      lpm_pkg::LPM_SW_STANDBY: if (wake_ssb) next_mode = lpm_pkg::LPM_NORMAL;
      lpm_pkg::LPM_DEEP_STANDBY: begin
        if (wake_deep) begin
          next_mode = lpm_pkg::LPM_DEEP_RESET;
          next_hold_cnt = 16'(DEEP_HOLD - 1);
        end
      end
      lpm_pkg::LPM_DEEP_RESET: begin
        if (hold_cnt == 16'h0000) begin
          next_mode = lpm_pkg::LPM_NORMAL;
          next_deep_recovered = 1'b1;
        end else begin
          next_hold_cnt = hold_cnt - 16'h0001;
        end
      end
      default: next_mode = lpm_pkg::LPM_NORMAL;
    endcase
    if (rd_ok && paddr == lpm_pkg::OFF_STATUS) next_deep_recovered = 1'b0;
    if (next_mode == lpm_pkg::LPM_NORMAL && mode == lpm_pkg::LPM_DEEP_RESET) next_deep_recovered = 1'b1;
  end

  // Outputs per mode
  always_comb begin
    next_ctrl = '0;
    next_ctrl.clk_from_low_speed_onchip_osc = ctrl.clk_from_low_speed_onchip_osc;
    case (next_mode)
      lpm_pkg::LPM_NORMAL: begin
        next_ctrl.cpu_clk_en = 1'b1;
        next_ctrl.module_clk_en = 1'b1;
        next_ctrl.timer_clk_en = 1'b1;
      end
      lpm_pkg::LPM_SLEEP: begin
        next_ctrl.module_clk_en = 1'b1;
        next_ctrl.timer_clk_en = 1'b1;
        next_ctrl.module_retain = 1'b1;
      end
      lpm_pkg::LPM_ALL_CLOCK_STOP: begin
        next_ctrl.timer_clk_en = module_stop_ctrl_a[lpm_pkg::BIT_TIMER_KEEP_RUNNING] == 1'b0;
        next_ctrl.module_retain = 1'b1;
      end
      lpm_pkg::LPM_SW_STANDBY: next_ctrl.module_retain = 1'b1;
      lpm_pkg::LPM_DEEP_STANDBY: begin
        next_ctrl.module_power_off = 1'b1;
        next_ctrl.ram0_power_off = !deep_standby_control_reg[lpm_pkg::BIT_RAM0_RETAIN];
      end
      lpm_pkg::LPM_DEEP_RESET: begin
        next_ctrl.module_power_off = 1'b1;
        next_ctrl.ram0_power_off = !deep_standby_control_reg[lpm_pkg::BIT_RAM0_RETAIN];
        next_ctrl.internal_reset = 1'b1;
        next_ctrl.clk_from_low_speed_onchip_osc = 1'b1;
      end
      default: next_ctrl.cpu_clk_en = 1'b1;
    endcase
  end

  // Register writes and APB answers
  always_comb begin
    next_standby_control_reg = standby_control_reg;
    next_deep_standby_control_reg = deep_standby_control_reg;
    next_module_stop_ctrl_a = module_stop_ctrl_a;
    next_module_stop_ctrl_b = module_stop_ctrl_b;
    next_module_stop_ctrl_c = module_stop_ctrl_c;
    next_wake_enable = wake_enable;
    next_pready = psel && penable && !pready;
    next_pslverr = psel && penable && !pready && !addr_mapped(paddr);
    next_prdata = 32'h0000_0000;
    if (wr_ok) begin
      case (paddr)
        lpm_pkg::OFF_STANDBY_CTRL: next_standby_control_reg = pwdata;
        lpm_pkg::OFF_DEEP_CTRL: next_deep_standby_control_reg = pwdata;
        lpm_pkg::OFF_MSTOP_A: next_module_stop_ctrl_a = pwdata;
        lpm_pkg::OFF_MSTOP_B: next_module_stop_ctrl_b = pwdata;
        lpm_pkg::OFF_MSTOP_C: next_module_stop_ctrl_c = pwdata;
        lpm_pkg::OFF_WAKE_ENABLE: next_wake_enable = pwdata;
        default: next_wake_enable = wake_enable;
      endcase
    end
    if (rd_ok) begin
      case (paddr)
        lpm_pkg::OFF_STANDBY_CTRL: next_prdata = standby_control_reg;
        lpm_pkg::OFF_DEEP_CTRL: next_prdata = deep_standby_control_reg;
        lpm_pkg::OFF_MSTOP_A: next_prdata = module_stop_ctrl_a;
        lpm_pkg::OFF_MSTOP_B: next_prdata = module_stop_ctrl_b;
        lpm_pkg::OFF_MSTOP_C: next_prdata = module_stop_ctrl_c;
        lpm_pkg::OFF_STATUS: next_prdata = {24'h000000, ctrl.clk_from_low_speed_onchip_osc, deep_recovered, 3'b000, 3'(mode)};
        lpm_pkg::OFF_WAKE_ENABLE: next_prdata = wake_enable;
        default: next_prdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      mode <= lpm_pkg::LPM_NORMAL;
      hold_cnt <= 16'h0000;
      deep_recovered <= 1'b0;
      ctrl <= 8'hC0;
      standby_control_reg <= lpm_pkg::RST_STANDBY_CTRL;
      deep_standby_control_reg <= lpm_pkg::RST_DEEP_CTRL;
      module_stop_ctrl_a <= lpm_pkg::RST_MSTOP_A;
      module_stop_ctrl_b <= lpm_pkg::RST_MSTOP_B;
      module_stop_ctrl_c <= lpm_pkg::RST_MSTOP_C;
      wake_enable <= lpm_pkg::RST_WAKE_ENABLE;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      mode <= next_mode;
      hold_cnt <= next_hold_cnt;
      deep_recovered <= next_deep_recovered;
      ctrl <= next_ctrl;
      standby_control_reg <= next_standby_control_reg;
      deep_standby_control_reg <= next_deep_standby_control_reg;
      module_stop_ctrl_a <= next_module_stop_ctrl_a;
      module_stop_ctrl_b <= next_module_stop_ctrl_b;
      module_stop_ctrl_c <= next_module_stop_ctrl_c;
      wake_enable <= next_wake_enable;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  // Checks
  property p_sleep_pick;
    @(posedge mclk) disable iff (rst)
    (mode == lpm_pkg::LPM_NORMAL && wait_exec && !standby_control_reg[lpm_pkg::BIT_STANDBY_SELECT] &&
     !clock_stop_ok) |=> mode == lpm_pkg::LPM_SLEEP;
  endproperty
  a_sleep_pick: assert property (p_sleep_pick) else $error("sleep not entered");
  property p_acs_pick;
    @(posedge mclk) disable iff (rst)
    (mode == lpm_pkg::LPM_NORMAL && wait_exec && !standby_control_reg[lpm_pkg::BIT_STANDBY_SELECT] &&
     clock_stop_ok) |=> mode == lpm_pkg::LPM_ALL_CLOCK_STOP;
  endproperty
  a_acs_pick: assert property (p_acs_pick) else $error("clock stop not entered");
  property p_sleep_wake;
    @(posedge mclk) disable iff (rst) (mode == lpm_pkg::LPM_SLEEP && |irq_pending) |=> mode == lpm_pkg::LPM_NORMAL;
  endproperty
  a_sleep_wake: assert property (p_sleep_wake) else $error("sleep wake lost");
  property p_nmi_wake;
    @(posedge mclk) disable iff (rst)
    ((mode == lpm_pkg::LPM_ALL_CLOCK_STOP || mode == lpm_pkg::LPM_SW_STANDBY) && nmi) |=> mode == lpm_pkg::LPM_NORMAL;
  endproperty
  a_nmi_wake: assert property (p_nmi_wake) else $error("nmi wake lost");
  property p_ssb_no_timer;
    @(posedge mclk) disable iff (rst)
    (mode == lpm_pkg::LPM_SW_STANDBY && !wake_ssb) |=> mode == lpm_pkg::LPM_SW_STANDBY;
  endproperty
  a_ssb_no_timer: assert property (p_ssb_no_timer) else $error("standby left without wake");
  property p_ssb_pick;
    @(posedge mclk) disable iff (rst)
    (mode == lpm_pkg::LPM_NORMAL && wait_exec && standby_control_reg[lpm_pkg::BIT_STANDBY_SELECT] &&
     !deep_standby_control_reg[lpm_pkg::BIT_DEEP_STANDBY_SELECT]) |=> mode == lpm_pkg::LPM_SW_STANDBY;
  endproperty
  a_ssb_pick: assert property (p_ssb_pick) else $error("standby not entered");
  property p_deep_hold;
    @(posedge mclk) disable iff (rst)
    (mode == lpm_pkg::LPM_DEEP_STANDBY && wake_deep) |=> ##1 ctrl.internal_reset [*2];
  endproperty
  a_deep_hold: assert property (p_deep_hold) else $error("internal reset not held");
  property p_deep_stay;
    @(posedge mclk) disable iff (rst)
    (mode == lpm_pkg::LPM_DEEP_STANDBY && !wake_deep) |=> mode == lpm_pkg::LPM_DEEP_STANDBY;
  endproperty
  a_deep_stay: assert property (p_deep_stay) else $error("deep standby left without wake");
  property p_deep_pick;
    @(posedge mclk) disable iff (rst)
    (mode == lpm_pkg::LPM_NORMAL && wait_exec && standby_control_reg[lpm_pkg::BIT_STANDBY_SELECT] &&
     deep_standby_control_reg[lpm_pkg::BIT_DEEP_STANDBY_SELECT]) |=> mode == lpm_pkg::LPM_DEEP_STANDBY;
  endproperty
  a_deep_pick: assert property (p_deep_pick) else $error("deep standby not entered");
  property p_ext_wake;
    @(posedge mclk) disable iff (rst)
    ((mode == lpm_pkg::LPM_ALL_CLOCK_STOP || mode == lpm_pkg::LPM_SW_STANDBY) && ext_wake) |=>
      mode == lpm_pkg::LPM_NORMAL;
  endproperty
  a_ext_wake: assert property (p_ext_wake) else $error("external line wake lost");
  property p_acs_periph;
    @(posedge mclk) disable iff (rst)
    (mode == lpm_pkg::LPM_ALL_CLOCK_STOP && (periph_wake.timer8 || periph_wake.osc_stop)) |=>
      mode == lpm_pkg::LPM_NORMAL;
  endproperty
  a_acs_periph: assert property (p_acs_periph) else $error("clock stop peripheral wake lost");
  property p_deep_release;
    @(posedge mclk) disable iff (rst)
    (mode == lpm_pkg::LPM_DEEP_RESET && hold_cnt == 16'h0000) |=>
      (mode == lpm_pkg::LPM_NORMAL && !ctrl.internal_reset && ctrl.clk_from_low_speed_onchip_osc);
  endproperty
  a_deep_release: assert property (p_deep_release) else $error("deep recovery not released together");
  property p_deep_power;
    @(posedge mclk) disable iff (rst)
    (mode == lpm_pkg::LPM_DEEP_STANDBY || mode == lpm_pkg::LPM_DEEP_RESET) |-> ctrl.module_power_off;
  endproperty
  a_deep_power: assert property (p_deep_power) else $error("modules powered in deep standby");
  property p_cpu_stopped;
    @(posedge mclk) disable iff (rst) mode != lpm_pkg::LPM_NORMAL |-> !ctrl.cpu_clk_en;
  endproperty
  a_cpu_stopped: assert property (p_cpu_stopped) else $error("cpu clock running in low power");
  property p_run_normal;
    @(posedge mclk) disable iff (rst) mode == lpm_pkg::LPM_NORMAL |-> (ctrl.cpu_clk_en && ctrl.module_clk_en);
  endproperty
  a_run_normal: assert property (p_run_normal) else $error("normal mode without clocks");
  c_sleep: cover property (@(posedge mclk) disable iff (rst) mode == lpm_pkg::LPM_SLEEP);
  c_acs: cover property (@(posedge mclk) disable iff (rst) mode == lpm_pkg::LPM_ALL_CLOCK_STOP);
  c_deep_back: cover property (@(posedge mclk) disable iff (rst)
    mode == lpm_pkg::LPM_DEEP_RESET ##1 mode == lpm_pkg::LPM_NORMAL);
  c_ssb: cover property (@(posedge mclk) disable iff (rst) mode == lpm_pkg::LPM_SW_STANDBY);
  c_deep: cover property (@(posedge mclk) disable iff (rst) mode == lpm_pkg::LPM_DEEP_STANDBY);
endmodule // lpm_sequencer

/* File: test/lpm_wake_model.sv */
// CPU and wake-source stand-in for the low-power mode sequencer
`timescale 1ns/1ps
module lpm_wake_model (
  input wire logic mclk,
  input wire logic rst,
  input wire logic wait_req,
  input wire logic wake_req,
  input wire logic [59:0] wake_vec,
  input wire lpm_pkg::lpm_mode_e mode,
  output logic wait_exec,
  output logic [15:0] irq_pending,
  output logic nmi,
  output logic [15:0] ext_irq,
  output lpm_pkg::lpm_periph_wake_s periph_wake,
  output lpm_pkg::lpm_deep_pins_s deep_pins
);
  logic [59:0] src;
  logic [59:0] next_src;
  // A source stays asserted until the device runs again, like an unserviced interrupt
  always_comb begin
    next_src = src;
    if (wake_req) begin
      next_src = wake_vec;
    end else if (mode == lpm_pkg::LPM_NORMAL) begin
      next_src = '0;
    end
  end
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      src <= '0;
      wait_exec <= 1'b0;
    end else begin
      src <= next_src;
      wait_exec <= wait_req;
    end
  end
  assign {irq_pending, nmi, ext_irq, periph_wake, deep_pins} = src;
endmodule // lpm_wake_model

/* File: test/tb_lpm_sequencer.sv */
// Self-checking bench for the low-power mode sequencer
`timescale 1ns/1ps
module tb_lpm_sequencer;
  localparam int HOLD = 4;
  localparam logic [31:0] TA [6] = '{32'hFFFFFF8F, 32'hFFFFFFCF, 32'hFFFFFFCF, 32'h7FFFFFCF, 32'hFFFFFFFF, 32'hFFFFFFCF};
  localparam logic [31:0] TB [6] = '{32'hFFFFFFFF, 32'hFFFFFFFE, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'hFFFFFFFF};
  localparam logic [31:0] TC [6] = '{32'hFFFF0000, 32'hFFFF0000, 32'hFFFE0000, 32'hFFFF0000, 32'hFFFFFFFF, 32'hFFFF0000};
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic wait_req = 1'b0;
  logic wake_req = 1'b0;
  logic [59:0] wake_vec = '0;
  logic wait_exec;
  logic [15:0] irq_pending;
  logic nmi;
  logic [15:0] ext_irq;
  lpm_pkg::lpm_periph_wake_s periph_wake;
  lpm_pkg::lpm_deep_pins_s deep_pins;
  lpm_pkg::lpm_ctrl_s ctrl;
  lpm_pkg::lpm_mode_e mode;
  int err_total = 0;
  int check_count = 0;

  lpm_sequencer #(.DEEP_HOLD(HOLD)) i_lpm_sequencer (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .wait_exec(wait_exec), .irq_pending(irq_pending), .nmi(nmi), .ext_irq(ext_irq),
    .periph_wake(periph_wake), .deep_pins(deep_pins), .ctrl(ctrl), .mode(mode));
  lpm_wake_model i_lpm_wake_model (.mclk(mclk), .rst(rst), .wait_req(wait_req), .wake_req(wake_req),
    .wake_vec(wake_vec), .mode(mode), .wait_exec(wait_exec), .irq_pending(irq_pending), .nmi(nmi),
    .ext_irq(ext_irq), .periph_wake(periph_wake), .deep_pins(deep_pins));

  always #4 mclk = ~mclk;

  task conclude();
    $display("errors %0d checks %0d", err_total, check_count);
    if (err_total == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task timeout();
    err_total++;
    $display("ERROR %0t wait ran out", $time);
    conclude();
  endtask
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q, output logic e);
    int n;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) timeout();
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
    chk(e, 0);
  endtask
  task rd(input logic [11:0] a, input logic [31:0] x, input logic ex);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, '0, q, e);
    chk(q, x);
    chk(e, ex);
  endtask
  task settle(input lpm_pkg::lpm_mode_e from);
    int n;
    n = 0;
    while (mode === from && n < 300) begin
      @(posedge mclk);
      n++;
    end
    if (n == 300) timeout();
  endtask
  task pulse_wake(input logic [59:0] v);
    wake_vec <= v;
    wake_req <= 1'b1;
    @(posedge mclk);
    wake_req <= 1'b0;
  endtask
  task enter(input lpm_pkg::lpm_mode_e m);
    wait_req <= 1'b1;
    @(posedge mclk);
    wait_req <= 1'b0;
    settle(lpm_pkg::LPM_NORMAL);
    chk(mode, m);
  endtask
  // Bit i of mask says whether source i ends mode m
  task trial(input lpm_pkg::lpm_mode_e m, input logic [59:0] mask, input int lo);
    int n;
    for (int i = lo; i < 60; i++) begin
      if (m == lpm_pkg::LPM_DEEP_STANDBY) begin
        wr(lpm_pkg::OFF_STANDBY_CTRL, 32'h00008000);
        wr(lpm_pkg::OFF_DEEP_CTRL, {31'h00000040, i[0]});
      end
      enter(m);
      case (m)
        lpm_pkg::LPM_SLEEP: chk(ctrl.module_clk_en & !ctrl.cpu_clk_en, 1);
        lpm_pkg::LPM_ALL_CLOCK_STOP: chk({ctrl.module_clk_en, ctrl.timer_clk_en}, 1);
        lpm_pkg::LPM_SW_STANDBY: chk({ctrl.timer_clk_en, ctrl.module_retain}, 1);
        default: chk({ctrl.module_power_off, ctrl.ram0_power_off}, {1'b1, !i[0]});
      endcase
      pulse_wake(60'h1 << i);
      if (!mask[i]) begin
        repeat (4) @(posedge mclk);
        chk(mode, m);
        pulse_wake(60'h1 << 43);
      end
      settle(m);
      if (m == lpm_pkg::LPM_DEEP_STANDBY) begin
        chk({mode, ctrl.internal_reset}, {lpm_pkg::LPM_DEEP_RESET, 1'b1});
        n = 0;
        while (mode === lpm_pkg::LPM_DEEP_RESET && n < 300) begin
          @(posedge mclk);
          n++;
        end
        chk(n, HOLD);
        chk({mode, ctrl}, {lpm_pkg::LPM_NORMAL, 8'hE1});
        rd(lpm_pkg::OFF_STATUS, 32'h000000C0, 1'b0);
        rd(lpm_pkg::OFF_STATUS, 32'h00000080, 1'b0);
      end else begin
        chk(mode, lpm_pkg::LPM_NORMAL);
      end
    end
  endtask

  initial begin
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    chk({mode, ctrl}, {lpm_pkg::LPM_NORMAL, 8'hC0});
    rd(lpm_pkg::OFF_MSTOP_A, lpm_pkg::RST_MSTOP_A, 1'b0);
    rd(lpm_pkg::OFF_MSTOP_C, lpm_pkg::RST_MSTOP_C, 1'b0);
    rd(lpm_pkg::OFF_WAKE_ENABLE, lpm_pkg::RST_WAKE_ENABLE, 1'b0);
    rd(12'h01C, 32'h00000000, 1'b1);
    trial(lpm_pkg::LPM_SLEEP, 60'hFFFFFFFF8000000, 27);
    for (int k = 0; k < 6; k++) begin
      wr(lpm_pkg::OFF_MSTOP_A, TA[k]);
      wr(lpm_pkg::OFF_MSTOP_B, TB[k]);
      wr(lpm_pkg::OFF_MSTOP_C, TC[k]);
      enter(k > 3 ? lpm_pkg::LPM_ALL_CLOCK_STOP : lpm_pkg::LPM_SLEEP);
      if (k > 3) chk(ctrl.timer_clk_en, k == 5);
      pulse_wake(60'h1 << 43);
      settle(k > 3 ? lpm_pkg::LPM_ALL_CLOCK_STOP : lpm_pkg::LPM_SLEEP);
    end
    rd(lpm_pkg::OFF_MSTOP_A, 32'hFFFFFFCF, 1'b0);
    // A masked external line must not wake, an unmasked one must
    wr(lpm_pkg::OFF_WAKE_ENABLE, 32'hFFFFFFFE);
    enter(lpm_pkg::LPM_ALL_CLOCK_STOP);
    pulse_wake(60'h1 << 27);
    repeat (4) @(posedge mclk);
    chk(mode, lpm_pkg::LPM_ALL_CLOCK_STOP);
    pulse_wake(60'h1 << 28);
    settle(lpm_pkg::LPM_ALL_CLOCK_STOP);
    chk(mode, lpm_pkg::LPM_NORMAL);
    wr(lpm_pkg::OFF_WAKE_ENABLE, lpm_pkg::RST_WAKE_ENABLE);
    trial(lpm_pkg::LPM_ALL_CLOCK_STOP, 60'h0000FFFFFF80000, 0);
    wr(lpm_pkg::OFF_STANDBY_CTRL, 32'h00008000);
    trial(lpm_pkg::LPM_SW_STANDBY, 60'h0000FFFFBF00000, 0);
    trial(lpm_pkg::LPM_DEEP_STANDBY, 60'h00008000377FFFF, 0);
    conclude();
  end
endmodule // tb_lpm_sequencer
